// ===== src/nsrb_host.sv
// Host controller that polls a NAND device's status byte over its pins.
// Assumes an AHB-Lite master with a single slave; hready is our own hreadyout.
`timescale 1ns/1ns
`default_nettype none

module nsrb_host (
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp,
	// NAND pins
	output nsrb_pkg::nsrb_pins_t     nand_pins,
	output logic                     nand_wp_n,
	input  wire logic [7:0]          nand_io_in,
	output logic [7:0]               nand_io_out,
	output logic                     nand_io_oe_n,
	input  wire logic                nand_rb_n_in,
	// Interrupt
	output logic                     irq
);

	// ==========================================================
	// Declarations
	localparam int IRQ_W_L = nsrb_pkg::IRQ_W;

	nsrb_pkg::nsrb_ahb_req_t req_q;
	nsrb_pkg::nsrb_state_t   state_q, state_d;
	logic [2:0]              ctrl_q;
	logic                    poll_pend_q;
	logic [7:0]              status_q;
	logic [IRQ_W_L-1:0]      irq_stat_q, irq_mask_q, irq_stat_d, evt;
	logic [11:0]             pwr_cnt_q;
	logic                    recov_done_q;
	logic                    rb_meta_q, rb_sync_q, rb_prev_q;
	logic                    eng_start, eng_read, eng_done;
	logic [7:0]              eng_byte, eng_rd_byte;
	logic [31:0]             rd_mux;

	// ==========================================================
	// AHB decode
	wire ahb_take    = hsel && hready && htrans[1];
	wire wr_en       = req_q.valid && req_q.write;
	wire wr_ctrl     = wr_en && (req_q.addr == nsrb_pkg::OFS_CTRL);
	wire wr_irq_stat = wr_en && (req_q.addr == nsrb_pkg::OFS_IRQ_STAT);
	wire wr_irq_mask = wr_en && (req_q.addr == nsrb_pkg::OFS_IRQ_MASK);
	wire [7:0] ra    = haddr[7:0];
	wire busy        = (state_q != nsrb_pkg::ST_IDLE);

	assign rd_mux = (ra == nsrb_pkg::OFS_CTRL)     ? {28'h000_0000, ctrl_q, poll_pend_q} :
	                (ra == nsrb_pkg::OFS_STATUS)   ? {21'h00_0000, recov_done_q, busy,
	                                                  rb_sync_q, status_q} :
	                (ra == nsrb_pkg::OFS_IRQ_STAT) ? {27'h000_0000, irq_stat_q} :
	                (ra == nsrb_pkg::OFS_IRQ_MASK) ? {27'h000_0000, irq_mask_q} :
	                32'h0000_0000;

	// Zero wait states; unmapped reads return zero, writes vanish
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q     <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (hready) begin
			req_q.valid <= ahb_take;
			req_q.write <= hwrite;
			req_q.addr  <= haddr[7:0];
			hrdata      <= (ahb_take && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Control registers
	wire poll_take = (state_q == nsrb_pkg::ST_IDLE) && poll_pend_q;
	wire poll_wr   = wr_ctrl && hwdata[nsrb_pkg::CTRL_POLL_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q      <= nsrb_pkg::CTRL_RESET;
			poll_pend_q <= 1'b0;
			irq_mask_q  <= nsrb_pkg::IRQ_RESET;
		end else begin
			poll_pend_q <= (poll_pend_q && !poll_take) || poll_wr;
			if (wr_ctrl) begin
				ctrl_q <= hwdata[nsrb_pkg::CTRL_WP_REL_BIT:nsrb_pkg::CTRL_REPEAT_BIT];
			end
			if (wr_irq_mask) begin
				irq_mask_q <= hwdata[IRQ_W_L-1:0];
			end
		end
	end

	wire ctrl_repeat  = ctrl_q[nsrb_pkg::CTRL_REPEAT_BIT - 1];
	wire ctrl_restore = ctrl_q[nsrb_pkg::CTRL_RESTORE_BIT - 1];
	wire ctrl_wp_rel  = ctrl_q[nsrb_pkg::CTRL_WP_REL_BIT - 1];

	// ==========================================================
	// Power-up recovery and write protect
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_cnt_q    <= 12'h000;
			recov_done_q <= 1'b0;
			nand_wp_n    <= 1'b0;
		end else begin
			if (!recov_done_q) begin
				pwr_cnt_q    <= pwr_cnt_q + 12'h001;
				recov_done_q <= (pwr_cnt_q == nsrb_pkg::PWR_RECOVERY_CYC - 12'h001);
			end
			nand_wp_n <= recov_done_q && ctrl_wp_rel;
		end
	end

	// ==========================================================
	// Ready/busy input; only the second and third stages are read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rb_meta_q <= 1'b1;
			rb_sync_q <= 1'b1;
			rb_prev_q <= 1'b1;
		end else begin
			rb_meta_q <= nand_rb_n_in;
			rb_sync_q <= rb_meta_q;
			rb_prev_q <= rb_sync_q;
		end
	end

	// ==========================================================
	// Poll sequencer
	// Repeat polling stays in status mode, so no new 70h is needed
	wire dev_ready     = status_q[nsrb_pkg::SB_READY_BIT] && status_q[nsrb_pkg::SB_ARRAY_IDLE_BIT];
	wire repeat_needed = ctrl_repeat && !dev_ready;
	wire final_check   = (state_q == nsrb_pkg::ST_CHECK) && !repeat_needed;

	always_comb begin
		state_d   = state_q;
		eng_start = 1'b0;
		eng_read  = 1'b0;
		eng_byte  = nsrb_pkg::CMD_READ_STATUS;
		unique case (state_q)
			nsrb_pkg::ST_WAIT_PWR: if (recov_done_q) begin
				state_d = nsrb_pkg::ST_IDLE;
			end
			nsrb_pkg::ST_IDLE: if (poll_pend_q) begin
				state_d   = nsrb_pkg::ST_CMD70;
				eng_start = 1'b1;
			end
			nsrb_pkg::ST_CMD70: if (eng_done) begin
				state_d   = nsrb_pkg::ST_READ;
				eng_start = 1'b1;
				eng_read  = 1'b1;
			end
			nsrb_pkg::ST_READ: if (eng_done) begin
				state_d = nsrb_pkg::ST_CHECK;
			end
			nsrb_pkg::ST_CHECK: if (repeat_needed) begin
				state_d   = nsrb_pkg::ST_READ;
				eng_start = 1'b1;
				eng_read  = 1'b1;
			end else if (ctrl_restore) begin
				state_d   = nsrb_pkg::ST_CMD00;
				eng_start = 1'b1;
				eng_byte  = nsrb_pkg::CMD_READ_PAGE;
			end else begin
				state_d = nsrb_pkg::ST_IDLE;
			end
			nsrb_pkg::ST_CMD00: if (eng_done) begin
				state_d = nsrb_pkg::ST_IDLE;
			end
			default: state_d = nsrb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q  <= nsrb_pkg::ST_WAIT_PWR;
			status_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (state_q == nsrb_pkg::ST_READ && eng_done) begin
				status_q <= eng_rd_byte & nsrb_pkg::SB_DEFINED_MASK;
			end
		end
	end

	nsrb_cycle u_cycle (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (eng_start),
		.is_read (eng_read),
		.wr_byte (eng_byte),
		.done    (eng_done),
		.rd_byte (eng_rd_byte),
		.pins    (nand_pins),
		.io_in   (nand_io_in),
		.io_out  (nand_io_out),
		.io_oe_n (nand_io_oe_n)
	);

	// ==========================================================
	// Events and interrupt; a new event wins over a write-one clear
	wire sb_idle = status_q[nsrb_pkg::SB_ARRAY_IDLE_BIT];

	always_comb begin
		evt = '0;
		evt[nsrb_pkg::IRQ_POLL_DONE_BIT] = final_check;
		evt[nsrb_pkg::IRQ_FAIL_BIT]      = final_check && sb_idle
		                                   && status_q[nsrb_pkg::SB_FAIL_BIT];
		evt[nsrb_pkg::IRQ_PREV_FAIL_BIT] = final_check && sb_idle
		                                   && status_q[nsrb_pkg::SB_PREV_FAIL_BIT];
		evt[nsrb_pkg::IRQ_PROTECTED_BIT] = final_check && !status_q[nsrb_pkg::SB_WRITABLE_BIT];
		evt[nsrb_pkg::IRQ_RB_READY_BIT]  = rb_sync_q && !rb_prev_q;
		irq_stat_d = (irq_stat_q & ~(wr_irq_stat ? hwdata[IRQ_W_L-1:0] : '0)) | evt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= nsrb_pkg::IRQ_RESET;
			irq        <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq        <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_status_cmd_done;
		(state_q == nsrb_pkg::ST_CMD70) && eng_done;
	endsequence

	sequence s_restore_taken;
		final_check && ctrl_restore;
	endsequence

	property p_no_cmd_before_recovery;
		!recov_done_q |-> nand_pins.ce_n && nand_pins.we_n;
	endproperty
	a_no_cmd_before_recovery: assert property (p_no_cmd_before_recovery)
		else $error("device addressed before power-up recovery");

	property p_wp_held_in_recovery;
		!recov_done_q |=> !nand_wp_n;
	endproperty
	a_wp_held_in_recovery: assert property (p_wp_held_in_recovery)
		else $error("write protect released during recovery");

	property p_read_after_status_cmd;
		s_status_cmd_done |=> (state_q == nsrb_pkg::ST_READ) && !nand_pins.re_n && nand_io_oe_n;
	endproperty
	a_read_after_status_cmd: assert property (p_read_after_status_cmd)
		else $error("status command not followed by read cycle");

	property p_restore_read_cmd;
		s_restore_taken |=> (state_q == nsrb_pkg::ST_CMD00) && nand_pins.cle
		                    && (nand_io_out == nsrb_pkg::CMD_READ_PAGE);
	endproperty
	a_restore_read_cmd: assert property (p_restore_read_cmd)
		else $error("read command not reissued after status poll");

	property p_poll_repeats_in_mode;
		(state_q == nsrb_pkg::ST_CHECK) && repeat_needed |=>
			(state_q == nsrb_pkg::ST_READ) && !nand_pins.cle && !nand_pins.re_n;
	endproperty
	a_poll_repeats_in_mode: assert property (p_poll_repeats_in_mode)
		else $error("repeat poll left status read mode");

	property p_dont_care_cleared;
		(state_q == nsrb_pkg::ST_READ) && eng_done |=> (status_q[4:2] == 3'b000);
	endproperty
	a_dont_care_cleared: assert property (p_dont_care_cleared)
		else $error("undefined status bits kept");

	property p_fail_needs_idle;
		$rose(irq_stat_q[nsrb_pkg::IRQ_FAIL_BIT]) |-> $past(sb_idle);
	endproperty
	a_fail_needs_idle: assert property (p_fail_needs_idle)
		else $error("fail reported while array busy");

	property p_irq_follows_status;
		|(irq_stat_q & irq_mask_q) |=> irq;
	endproperty
	a_irq_follows_status: assert property (p_irq_follows_status)
		else $error("interrupt not raised for unmasked status");

endmodule // nsrb_host

`default_nettype wire

// ===== src/nsrb_pkg.sv
// Constants, register map and bundle types of the NAND status poller.
// Assumes a 250 MHz system clock; every timing count below except IO_SYNC_CYC derives from it.
`default_nettype none

package nsrb_pkg;

	// ==========================================================
	// Clock and timing
	localparam int          CLK_NS             = 4;
	localparam int          PWR_RECOVERY_NS    = 10000;
	localparam logic [11:0] PWR_RECOVERY_CYC   = 12'((PWR_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
	localparam int          STROBE_LOW_NS      = 22;
	localparam int          STROBE_HIGH_NS     = 15;
	localparam logic [3:0]  STROBE_LOW_CYC     = 4'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  STROBE_HIGH_CYC    = 4'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0]  IO_SYNC_CYC        = 4'h2;

	// ==========================================================
	// Device command codes
	localparam logic [7:0]  CMD_READ_STATUS    = 8'h70;
	localparam logic [7:0]  CMD_READ_PAGE      = 8'h00;

	// ==========================================================
	// Status byte fields of the device
	localparam int          SB_FAIL_BIT        = 0;
	localparam int          SB_PREV_FAIL_BIT   = 1;
	localparam int          SB_ARRAY_IDLE_BIT  = 5;
	localparam int          SB_READY_BIT       = 6;
	localparam int          SB_WRITABLE_BIT    = 7;
	localparam logic [7:0]  SB_DEFINED_MASK    = 8'hE3;

	// ==========================================================
	// Register map of the controller
	localparam logic [7:0]  OFS_CTRL           = 8'h00;
	localparam logic [7:0]  OFS_STATUS         = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT       = 8'h08;
	localparam logic [7:0]  OFS_IRQ_MASK       = 8'h0C;
	localparam int          CTRL_POLL_BIT      = 0;
	localparam int          CTRL_REPEAT_BIT    = 1;
	localparam int          CTRL_RESTORE_BIT   = 2;
	localparam int          CTRL_WP_REL_BIT    = 3;
	localparam logic [2:0]  CTRL_RESET         = 3'h0;
	localparam int          IRQ_W              = 5;
	localparam int          IRQ_POLL_DONE_BIT  = 0;
	localparam int          IRQ_FAIL_BIT       = 1;
	localparam int          IRQ_PREV_FAIL_BIT  = 2;
	localparam int          IRQ_RB_READY_BIT   = 3;
	localparam int          IRQ_PROTECTED_BIT  = 4;
	localparam logic [4:0]  IRQ_RESET          = 5'h00;

	// ==========================================================
	// Types
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
	} nsrb_pins_t;

	localparam nsrb_pins_t  PINS_IDLE          = 5'h13;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} nsrb_ahb_req_t;

	typedef enum logic [2:0] {
		ST_WAIT_PWR = 3'b000,
		ST_IDLE     = 3'b001,
		ST_CMD70    = 3'b010,
		ST_READ     = 3'b011,
		ST_CHECK    = 3'b100,
		ST_CMD00    = 3'b101
	} nsrb_state_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_LOW  = 2'b01,
		PH_HIGH = 2'b10
	} nsrb_phase_t;

endpackage

`default_nettype wire

// ===== src/nsrb_cycle.sv
// One bus cycle on the NAND pins: a command latch or a data read.
// Assumes io_in comes straight from a pin; it is synchronised here.
`timescale 1ns/1ns
`default_nettype none

module nsrb_cycle (
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// Request
	input  wire logic                start,
	input  wire logic                is_read,
	input  wire logic [7:0]          wr_byte,
	output logic                     done,
	output logic [7:0]               rd_byte,
	// Pins
	output nsrb_pkg::nsrb_pins_t     pins,
	input  wire logic [7:0]          io_in,
	output logic [7:0]               io_out,
	output logic                     io_oe_n
);

	nsrb_pkg::nsrb_phase_t phase_q;
	logic [3:0]            cnt_q;
	logic                  rd_q;
	logic [7:0]            io_meta_q;
	logic [7:0]            io_sync_q;

	wire cnt_zero = (cnt_q == 4'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_meta_q <= 8'h00;
			io_sync_q <= 8'h00;
		end else begin
			io_meta_q <= io_in;
			io_sync_q <= io_meta_q;
		end
	end

	// ==========================================================
	// Strobe sequencer
	// Read strobe is stretched by the sync depth so the sampled byte is settled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= nsrb_pkg::PH_IDLE;
			cnt_q   <= 4'h0;
			rd_q    <= 1'b0;
			done    <= 1'b0;
			rd_byte <= 8'h00;
			pins    <= nsrb_pkg::PINS_IDLE;
			io_out  <= 8'h00;
			io_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			unique case (phase_q)
				nsrb_pkg::PH_IDLE: if (start) begin
					phase_q   <= nsrb_pkg::PH_LOW;
					rd_q      <= is_read;
					pins.ce_n <= 1'b0;
					pins.cle  <= !is_read;
					pins.we_n <= is_read;
					pins.re_n <= !is_read;
					io_out    <= wr_byte;
					io_oe_n   <= is_read;
					cnt_q     <= is_read ? nsrb_pkg::STROBE_LOW_CYC + nsrb_pkg::IO_SYNC_CYC - 4'h1
					                     : nsrb_pkg::STROBE_LOW_CYC - 4'h1;
				end
				nsrb_pkg::PH_LOW: if (cnt_zero) begin
					phase_q   <= nsrb_pkg::PH_HIGH;
					pins.we_n <= 1'b1;
					pins.re_n <= 1'b1;
					cnt_q     <= nsrb_pkg::STROBE_HIGH_CYC - 4'h1;
					if (rd_q) begin
						rd_byte <= io_sync_q;
					end
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
				nsrb_pkg::PH_HIGH: if (cnt_zero) begin
					phase_q <= nsrb_pkg::PH_IDLE;
					pins    <= nsrb_pkg::PINS_IDLE;
					io_oe_n <= 1'b1;
					done    <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
				default: phase_q <= nsrb_pkg::PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checks
	property p_cmd_latch_shape;
		@(posedge hclk) disable iff (!hresetn)
		$fell(pins.we_n) |-> (pins.cle && !io_oe_n && !pins.ce_n) ##0 !pins.we_n [*6] ##1 pins.we_n;
	endproperty
	a_cmd_latch_shape: assert property (p_cmd_latch_shape)
		else $error("command latch strobe malformed");

endmodule // nsrb_cycle

`default_nettype wire

// ===== bench/nsrb_nand_model.sv
// Behavioural NAND device: latches commands, answers reads, drives R/B#.
// Assumes the bench resolves the shared io bus and pulls the R/B# line up.
`timescale 1ns/1ns
`default_nettype none

module nsrb_nand_model (
	// Host side pins
	input  wire nsrb_pkg::nsrb_pins_t pins,
	input  wire logic [7:0]           io_bus,
	input  wire logic                 wp_n,
	// Device condition set by the bench
	input  wire logic                 st_fail,
	input  wire logic                 st_prev,
	input  wire logic                 st_abusy,
	input  wire logic                 st_busy,
	input  wire logic                 st_prot,
	input  wire logic                 vcc_ok,
	// Device outputs and activity counters
	output wire logic                 io_en,
	output wire logic [7:0]           io_drv,
	output wire logic                 rb_low,
	output logic [7:0]                cmd_last,
	output int                        cmd_total,
	output int                        reads
);
	logic       stat_mode_q;
	logic [7:0] last_q;
	wire  logic [7:0] sb;

	// ==========================================================
	// Status byte, live while selected
	// Don't-care bits driven high so a leak shows up at the host
	assign sb = {wp_n & ~st_prot, ~st_busy, ~st_abusy, 3'b111, st_prev, st_fail};
	// Below the lockout level the device neither answers nor latches
	assign #8 io_en = vcc_ok & ~pins.ce_n & ~pins.re_n;
	// Released bus shows the inverse of the last byte, not a stale copy
	assign io_drv = !io_en ? ~last_q : stat_mode_q ? sb : 8'hA5;
	assign rb_low = st_busy;

	// ==========================================================
	// Command latch and read counting
	initial begin
		stat_mode_q = 1'b0;
		last_q = 8'h00;
		cmd_total = 0;
		reads = 0;
	end
	// No array is touched, so no setup/confirm pair ever starts one
	always @(posedge pins.we_n) begin
		if (vcc_ok && !pins.ce_n && pins.cle) begin
			cmd_last <= io_bus;
			cmd_total <= cmd_total + 1;
			stat_mode_q <= io_bus == nsrb_pkg::CMD_READ_STATUS;
		end
	end
	always @(posedge pins.re_n) begin
		if (vcc_ok && !pins.ce_n) begin
			last_q <= io_drv;
			reads <= reads + 1;
		end
	end
endmodule // nsrb_nand_model

`default_nettype wire

// ===== bench/nsrb_host_tb_top.sv
// Bench of the NAND status poller: AHB-Lite master tasks and scenarios.
// Assumes one slave, so hready is the poller's own hreadyout.
`timescale 1ns/1ns
`default_nettype none

module nsrb_host_tb_top;
	logic                 hclk = 1'b0;
	logic                 hresetn = 1'b0;
	logic                 hsel = 1'b0;
	logic                 hwrite = 1'b0;
	logic [1:0]           htrans = 2'b00;
	logic [31:0]          haddr = 32'h0000_0000;
	logic [31:0]          hwdata = 32'h0000_0000;
	logic [4:0]           st = 5'h00;
	wire  logic           hready;
	wire  logic           hresp;
	wire  logic           irq;
	wire  logic           wp_n;
	wire  logic           io_oe_n;
	wire  logic           io_en;
	wire  logic           rb_low;
	wire  logic [31:0]    hrdata;
	wire  logic [7:0]     io_out;
	wire  logic [7:0]     io_drv;
	wire  logic [7:0]     io_bus;
	wire  logic [7:0]     cmd_last;
	wire  nsrb_pkg::nsrb_pins_t pins;
	int                   cmd_total;
	int                   reads;
	int                   cyc = 0;
	int                   miscompares = 0;
	int                   check_count = 0;

	// ==========================================================
	// Clock, bus resolution and instances
	always #2 hclk = ~hclk;
	always @(posedge hclk) cyc <= hresetn ? cyc + 1 : 0;
	assign io_bus = !io_oe_n ? io_out : io_drv;

	nsrb_host i_nsrb_host (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .nand_pins(pins),
		.nand_wp_n(wp_n), .nand_io_in(io_bus), .nand_io_out(io_out),
		.nand_io_oe_n(io_oe_n), .nand_rb_n_in(~rb_low), .irq(irq)
	);
	nsrb_nand_model i_nsrb_nand_model (
		.pins(pins), .io_bus(io_bus), .wp_n(wp_n), .st_fail(st[4]), .st_prev(st[3]),
		.st_abusy(st[2]), .st_busy(st[1]), .st_prot(st[0]), .io_en(io_en),
		.io_drv(io_drv), .rb_low(rb_low), .cmd_last(cmd_last), .cmd_total(cmd_total),
		.reads(reads), .vcc_ok(hresetn)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wait_done(output logic [31:0] sb, output logic [31:0] ist);
		int n;
		n = 0;
		do begin
			ahb(1'b0, nsrb_pkg::OFS_IRQ_STAT, 32'h0, ist);
			n++;
		end while (ist[0] !== 1'b1 && n < 2000);
		do ahb(1'b0, nsrb_pkg::OFS_STATUS, 32'h0, sb);
		while (sb[9] !== 1'b0 && n++ < 2000);
	endtask

	task automatic poll(input logic [3:0] ctrl, output logic [31:0] sb, output logic [31:0] ist);
		ahb(1'b1, nsrb_pkg::OFS_IRQ_STAT, 32'h1F, sb);
		ahb(1'b1, nsrb_pkg::OFS_CTRL, {28'h000_0000, ctrl}, sb);
		wait_done(sb, ist);
	endtask

	// Condition bits: fail, prev fail, array busy, busy, protected
	function automatic logic [7:0] exp_sb(input logic [4:0] s);
		return {~s[0], ~s[1], ~s[2], 3'b000, s[3], s[4]};
	endfunction
	function automatic logic [4:0] exp_ev(input logic [4:0] s);
		return {s[0], 1'b0, s[3] & ~s[2], s[4] & ~s[2], 1'b1};
	endfunction

	task automatic finish_test;
		$display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] q, ist;
		check("pins idle", 32'(nsrb_pkg::PINS_IDLE), 32'(pins));
		check("wp_n", 32'h0, 32'(wp_n));
		check("io_oe_n", 32'h1, 32'(io_oe_n));
		check("irq", 32'h0, 32'(irq));
		check("hresp", 32'h0, 32'(hresp));
		ahb(1'b1, 8'h10, 32'h0000_FFFF, q);
		ahb(1'b0, 8'h10, 32'h0, q);
		check("unmapped", 32'h0, q);
		ahb(1'b0, nsrb_pkg::OFS_IRQ_MASK, 32'h0, q);
		check("irq mask", 32'h0, q);
		ahb(1'b1, nsrb_pkg::OFS_CTRL, 32'h1, q);
		while (cyc < 2400) @(posedge hclk);
		check("early commands", 32'h0, 32'(cmd_total));
		ahb(1'b0, nsrb_pkg::OFS_STATUS, 32'h0, q);
		check("recovery flag", 32'h0, 32'(q[10]));
		wait_done(q, ist);
		check("protected byte", 32'h60, 32'(q[7:0]));
		check("protected events", 32'h11, ist & 32'h17);
		$display("Test reset done");
	endtask

	task automatic t_codes;
		logic [4:0] cases [5] = '{5'h10, 5'h08, 5'h14, 5'h01, 5'h18};
		logic [31:0] sb, ist;
		ahb(1'b1, nsrb_pkg::OFS_IRQ_MASK, 32'h2, sb);
		foreach (cases[i]) begin
			st <= cases[i];
			poll(4'h9, sb, ist);
			check("wp_n", 32'h1, 32'(wp_n));
			check("status byte", 32'(exp_sb(cases[i])), 32'(sb[7:0]));
			check("events", 32'(exp_ev(cases[i])), ist & 32'h17);
			check("irq", 32'(cases[i][4] & ~cases[i][2]), 32'(irq));
		end
		check("last command", 32'h70, 32'(cmd_last));
		$display("Test codes done");
	endtask

	task automatic t_repeat;
		logic [31:0] sb, ist;
		int c0, r0;
		st <= 5'h06;
		c0 = cmd_total;
		r0 = reads;
		ahb(1'b1, nsrb_pkg::OFS_IRQ_STAT, 32'h1F, sb);
		ahb(1'b1, nsrb_pkg::OFS_CTRL, 32'hB, sb);
		// Nothing may complete while the device stays busy
		repeat (300) @(posedge hclk);
		ahb(1'b0, nsrb_pkg::OFS_STATUS, 32'h0, sb);
		check("busy and rb", 32'h2, 32'(sb[9:8]));
		check("no reissue", 32'(c0 + 1), 32'(cmd_total));
		check("repeat reads", 32'h1, 32'(reads - r0 > 2));
		st <= 5'h00;
		wait_done(sb, ist);
		check("live status", 32'hE0, 32'(sb[7:0]));
		check("rb rose event", 32'h1, 32'(ist[3]));
		check("rb synced", 32'h1, 32'(sb[8]));
		$display("Test repeat done");
	endtask

	task automatic t_restore;
		logic [31:0] sb, ist;
		int c0;
		c0 = cmd_total;
		ahb(1'b1, nsrb_pkg::OFS_IRQ_MASK, 32'h1, sb);
		poll(4'hD, sb, ist);
		check("restore command", 32'h0, 32'(cmd_last));
		check("command count", 32'(c0 + 2), 32'(cmd_total));
		check("irq done", 32'h1, 32'(irq));
		ahb(1'b1, nsrb_pkg::OFS_IRQ_STAT, 32'h1F, sb);
		ahb(1'b0, nsrb_pkg::OFS_IRQ_STAT, 32'h0, ist);
		check("cleared", 32'h0, ist & 32'h17);
		check("irq cleared", 32'h0, 32'(irq));
		$display("Test restore done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_codes;
		t_repeat;
		t_restore;
		finish_test;
	end
	initial begin
		repeat (30000) @(posedge hclk);
		miscompares++;
		$display("Watchdog expired");
		finish_test;
	end
endmodule // nsrb_host_tb_top

`default_nettype wire
